// file: verilog/ascm_slot_map.sv
// Channel slot mapping and serial transmit for four audio channels.
//
// What this block does
// - Line select 0 sends channel on primary pin.
// - Line select 1 sends channel on secondary pin.
// - Slot 0-31: TDM slot or left slot.
// - Slot 32-63: TDM slot or right minus 32.
// - Reset maps channels 1-4 to slots 0-3, primary.
// - One byte register per channel, bit 7 zero.
// - Unused cycles drive zero, or release when set.
`timescale 1ns/10ps
`default_nettype none
`include "ascm_regs.svh"

module ascm_slot_map #(
	parameter int SLOT_BITS = 32
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// Register port
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	output logic [7:0] reg_rdata_o,
	// Format and fill settings
	input wire logic fmt_half_i,
	input wire logic fill_hiz_i,
	// Serial link from the host
	input wire logic bclk_i,
	input wire logic fsync_i,
	// Channel samples
	input wire logic [4*SLOT_BITS-1:0] ch_sample_i,
	// Serial data lines
	output logic prim_data_o,
	output logic prim_oe_o,
	output logic sec_data_o,
	output logic sec_oe_o
);

	localparam int SB = $clog2(SLOT_BITS);
	localparam int PW = 6 + SB + 1;
	localparam logic [7:0] RST_VAL [4] = '{`ASCM_CHANNEL_SLOT_ASSIGN_CFG_RST, `ASCM_CH2_SLOT_CFG_RST,
		`ASCM_CH3_SLOT_CFG_RST, `ASCM_CH4_SLOT_CFG_RST};

	// ****************************************************************
	// Register file
	// ****************************************************************

	function automatic logic [2:0] decode_addr(input logic [7:0] addr);
		case (addr)
			`ASCM_CHANNEL_SLOT_ASSIGN_CFG_OFS: decode_addr = 3'h4;
			`ASCM_CH2_SLOT_CFG_OFS: decode_addr = 3'h5;
			`ASCM_CH3_SLOT_CFG_OFS: decode_addr = 3'h6;
			`ASCM_CH4_SLOT_CFG_OFS: decode_addr = 3'h7;
			default: decode_addr = 3'h0;
		endcase
	endfunction

	logic [7:0] cfg [4];
	logic [2:0] wdec;
	logic [2:0] rdec;

	assign wdec = decode_addr(reg_addr_i);
	assign rdec = decode_addr(reg_addr_i);

	for (genvar g = 0; g < 4; g++) begin : g_ch
		logic [6:0] cfg_r;
		always_ff @(posedge clk_i) begin
			if (reset_i) begin
				cfg_r <= RST_VAL[g][6:0];
			end else if (reg_wr_i && wdec == {1'b1, 2'(g)}) begin
				cfg_r <= reg_wdata_i[6:0];
			end
		end
		// Reserved top bit always reads zero.
		assign cfg[g] = {1'b0, cfg_r};
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			reg_rdata_o <= `ASCM_UNMAPPED_RDATA;
		end else if (rdec[2]) begin
			reg_rdata_o <= cfg[rdec[1:0]];
		end else begin
			reg_rdata_o <= `ASCM_UNMAPPED_RDATA;
		end
	end

	// ****************************************************************
	// Link synchronisers and edge detect
	// ****************************************************************

	logic bclk_s1_r;
	logic bclk_s2_r;
	logic bclk_s3_r;
	logic fsync_s1_r;
	logic fsync_s2_r;
	logic sync_q_r;
	logic bclk_rise;
	logic bclk_fall;
	logic fs_edge;

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			bclk_s1_r <= 1'b0;
			bclk_s2_r <= 1'b0;
			bclk_s3_r <= 1'b0;
			fsync_s1_r <= 1'b0;
			fsync_s2_r <= 1'b0;
		end else begin
			bclk_s1_r <= bclk_i;
			bclk_s2_r <= bclk_s1_r;
			bclk_s3_r <= bclk_s2_r;
			fsync_s1_r <= fsync_i;
			fsync_s2_r <= fsync_s1_r;
		end
	end

	assign bclk_rise = bclk_s2_r & ~bclk_s3_r;
	assign bclk_fall = ~bclk_s2_r & bclk_s3_r;
	// TDM frames open on the sync rise; half-frame formats open a half on either sync edge.
	assign fs_edge = (fmt_half_i == ascm_pkg::ASCM_FMT_HALF) ? (fsync_s2_r != sync_q_r) :
		(fsync_s2_r & ~sync_q_r);

	// ****************************************************************
	// Frame position
	// ****************************************************************

	logic [PW-1:0] pos_r;
	logic half_r;
	logic started_r;

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			sync_q_r <= 1'b0;
			pos_r <= '1;
			half_r <= 1'b0;
			started_r <= 1'b0;
		end else if (bclk_rise) begin
			sync_q_r <= fsync_s2_r;
			if (fs_edge) begin
				pos_r <= '0;
				half_r <= ~fsync_s2_r;
				started_r <= 1'b1;
			end else if (!pos_r[PW-1]) begin
				// Saturates so a frame longer than 64 slots only sends fill.
				pos_r <= PW'(pos_r + 1'b1);
			end
		end
	end

	// ****************************************************************
	// Sample capture
	// ****************************************************************

	logic [SLOT_BITS-1:0] smp_r [4];

	// Samples are captured once per frame so both halves come from one set.
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			for (int c = 0; c < 4; c++) begin
				smp_r[c] <= '0;
			end
		end else if (bclk_rise && fs_edge && fsync_s2_r) begin
			for (int c = 0; c < 4; c++) begin
				smp_r[c] <= ch_sample_i[c*SLOT_BITS +: SLOT_BITS];
			end
		end
	end

	// ****************************************************************
	// Slot match and line steering
	// ****************************************************************

	ascm_pkg::ascm_slot_t slot_now;
	logic in_range;
	logic [SB-1:0] bit_idx;
	logic prim_hit;
	logic prim_bit;
	logic sec_hit;
	logic sec_bit;

	always_comb begin
		if (fmt_half_i == ascm_pkg::ASCM_FMT_HALF) begin
			slot_now = {half_r, pos_r[SB+4:SB]};
			in_range = started_r & ~pos_r[PW-1] & ~pos_r[SB+5];
		end else begin
			slot_now = pos_r[SB+5:SB];
			in_range = started_r & ~pos_r[PW-1];
		end
		bit_idx = SB'(SLOT_BITS - 1) - pos_r[SB-1:0];
	end

	// Lowest channel wins when two share a slot on the same line.
	always_comb begin
		prim_hit = 1'b0;
		prim_bit = 1'b0;
		sec_hit = 1'b0;
		sec_bit = 1'b0;
		for (int c = 3; c >= 0; c--) begin
			if (in_range && cfg[c][`ASCM_SLOT_MSB:`ASCM_SLOT_LSB] == slot_now) begin
				if (cfg[c][`ASCM_LINE_SEL_BIT] == ascm_pkg::ASCM_LINE_PRIMARY) begin
					prim_hit = 1'b1;
					prim_bit = smp_r[c][bit_idx];
				end else begin
					sec_hit = 1'b1;
					sec_bit = smp_r[c][bit_idx];
				end
			end
		end
	end

	// ****************************************************************
	// Output drive on the falling bit clock edge
	// ****************************************************************

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			prim_data_o <= 1'b0;
			prim_oe_o <= 1'b0;
			sec_data_o <= 1'b0;
			sec_oe_o <= 1'b0;
		end else if (bclk_fall) begin
			prim_data_o <= prim_hit & prim_bit;
			prim_oe_o <= prim_hit | ~fill_hiz_i;
			sec_data_o <= sec_hit & sec_bit;
			sec_oe_o <= sec_hit | ~fill_hiz_i;
		end
	end

endmodule // ascm_slot_map

`default_nettype wire

// file: verilog/ascm_regs.svh
// Register offsets, field positions and reset values of the channel slot map.
`ifndef ASCM_REGS_SVH
`define ASCM_REGS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define ASCM_CHANNEL_SLOT_ASSIGN_CFG_OFS 8'h0B
`define ASCM_CH2_SLOT_CFG_OFS 8'h0C
`define ASCM_CH3_SLOT_CFG_OFS 8'h0D
`define ASCM_CH4_SLOT_CFG_OFS 8'h0E

// ****************************************************************
// Reset values
// ****************************************************************
`define ASCM_CHANNEL_SLOT_ASSIGN_CFG_RST 8'h00
`define ASCM_CH2_SLOT_CFG_RST 8'h01
`define ASCM_CH3_SLOT_CFG_RST 8'h02
`define ASCM_CH4_SLOT_CFG_RST 8'h03

// ****************************************************************
// Field positions
// ****************************************************************
`define ASCM_RSVD_BIT 7
`define ASCM_LINE_SEL_BIT 6
`define ASCM_SLOT_MSB 5
`define ASCM_SLOT_LSB 0
`define ASCM_UNMAPPED_RDATA 8'h00

`endif

// file: verilog/ascm_pkg.sv
// Types shared by the channel slot map.
`default_nettype none
package ascm_pkg;

	typedef logic [5:0] ascm_slot_t;

	typedef enum logic {
		ASCM_LINE_PRIMARY = 1'b0,
		ASCM_LINE_SECONDARY = 1'b1
	} ascm_line_t;

	typedef enum logic {
		ASCM_FMT_TDM = 1'b0,
		ASCM_FMT_HALF = 1'b1
	} ascm_fmt_t;

endpackage

`default_nettype wire

// file: test/ascm_monitor.sv
// Checker on the slot map ports.
`timescale 1ns/10ps
`default_nettype none
module ascm_monitor (
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// Registers
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic [7:0] reg_rdata_o,
	// Lines
	input wire logic bclk_i,
	input wire logic prim_data_o,
	input wire logic prim_oe_o,
	input wire logic sec_data_o,
	input wire logic sec_oe_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	sequence s_wr;
		reg_wr_i && reg_addr_i inside {[8'h0B:8'h0E]} ##1 !reg_wr_i && $stable(reg_addr_i);
	endsequence
	a_rst_quiet: assert property ($fell(reset_i) |-> !(prim_oe_o | sec_oe_o | prim_data_o | sec_data_o))
		else $error("line active after reset");
	a_rst_cfg: assert property ($fell(reset_i) && !reg_wr_i && reg_addr_i == 8'h0C |=> reg_rdata_o == 8'h01)
		else $error("bad reset map");
	a_rsvd_zero: assert property (!reg_rdata_o[7])
		else $error("reserved bit set");
	a_unmap_zero: assert property (!(reg_addr_i inside {[8'h0B:8'h0E]}) |=> reg_rdata_o == 8'h00)
		else $error("unmapped read not zero");
	a_wr_back: assert property (s_wr |=> reg_rdata_o[6:0] == $past(reg_wdata_i[6:0], 2))
		else $error("write not read back");
	// A stopped clock must leave the lines frozen, or the host sees noise.
	a_idle_hold: assert property (!bclk_i [*8] |-> $stable(prim_data_o) && $stable(sec_data_o))
		else $error("data moved while idle");
	a_prim_rel: assert property (!prim_oe_o |-> !prim_data_o)
		else $error("primary released with data");
	a_sec_rel: assert property (!sec_oe_o |-> !sec_data_o)
		else $error("secondary released with data");
endmodule // ascm_monitor
`default_nettype wire

// file: test/ascm_host.sv
// Host model that clocks frames and samples both lines.
`timescale 1ns/10ps
`default_nettype none
module ascm_host (
	// Device lines
	input wire logic prim_data_i,
	input wire logic prim_oe_i,
	input wire logic sec_data_i,
	input wire logic sec_oe_i,
	// Link and capture
	output logic bclk_o = 1'h0,
	output logic fsync_o = 1'h0,
	output logic [7:0] cap_o = 8'h00,
	output logic cap_tg_o = 1'h0
);
	// The clock stands low between frames; rise i samples position i-1.
	task automatic frame(input int h, input bit half);
		#7;
		for (int i = 0; i <= 2 * h; i++) begin
			fsync_o = half ? i < h : i == 0;
			#200 bclk_o = 1'h1;
			if (i > 0) begin
				cap_o = {4'h0, prim_oe_i, prim_data_i, sec_oe_i, sec_data_i};
				cap_tg_o = ~cap_tg_o;
			end
			#200 bclk_o = 1'h0;
		end
	endtask
endmodule // ascm_host
`default_nettype wire

// file: test/tb_top.sv
// Bench for the slot map.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	localparam int SB = 4;
	logic clk_i = 1'h0, reset_i = 1'h1, reg_wr_i = 1'h0, fmt_half_i = 1'h0, fill_hiz_i = 1'h0;
	logic [7:0] reg_addr_i = 8'h0C, reg_wdata_i = 8'h00, reg_rdata_o, cap;
	logic [4*SB-1:0] ch_sample_i = '0;
	logic bclk, fsync, prim_data_o, prim_oe_o, sec_data_o, sec_oe_o, cap_tg;
	logic [6:0] cfg [4];
	logic [7:0] expq [$];
	int fail_count = 0, total_checks = 0;
	initial forever #25 clk_i = ~clk_i;
	ascm_slot_map #(.SLOT_BITS(SB)) dut (.clk_i(clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rdata_o(reg_rdata_o), .fmt_half_i(fmt_half_i),
		.fill_hiz_i(fill_hiz_i), .bclk_i(bclk), .fsync_i(fsync), .ch_sample_i(ch_sample_i),
		.prim_data_o(prim_data_o), .prim_oe_o(prim_oe_o), .sec_data_o(sec_data_o), .sec_oe_o(sec_oe_o));
	ascm_host u_host (.prim_data_i(prim_data_o), .prim_oe_i(prim_oe_o), .sec_data_i(sec_data_o),
		.sec_oe_i(sec_oe_o), .bclk_o(bclk), .fsync_o(fsync), .cap_o(cap), .cap_tg_o(cap_tg));
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		total_checks++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr_i = a;
		reg_wdata_i = d;
		reg_wr_i = 1'h1;
		@(negedge clk_i);
		reg_wr_i = 1'h0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		reg_addr_i = a;
		@(negedge clk_i);
		chk(reg_rdata_o, e);
	endtask
	function automatic logic [7:0] ex(input int p, input int h, input bit half);
		logic [7:0] r;
		int s;
		r = {4'h0, ~fill_hiz_i, 1'h0, ~fill_hiz_i, 1'h0};
		s = (half && p >= h) ? 32 + (p - h) / SB : p / SB;
		if (half && p % h >= 32 * SB) s = -1;
		for (int c = 3; c >= 0; c--) begin
			if (cfg[c][5:0] == s && cfg[c][6]) r[1:0] = {1'h1, ch_sample_i[c * SB + SB - 1 - p % SB]};
			if (cfg[c][5:0] == s && !cfg[c][6]) r[3:2] = {1'h1, ch_sample_i[c * SB + SB - 1 - p % SB]};
		end
		return r;
	endfunction
	task automatic run(input bit half);
		int h;
		h = half ? 34 * SB : 32 * SB;
		fmt_half_i = half;
		for (int p = 0; p < 2 * h; p++) expq.push_back(ex(p, h, half));
		u_host.frame(h, half);
		repeat (4) @(negedge clk_i);
		chk(8'(expq.size()), 8'h00);
	endtask
	// The toggle settles from unknown at time zero; that is not a capture.
	always @(cap_tg) if ($time > 0) chk(cap, expq.size() > 0 ? expq.pop_front() : 8'hFF);
	initial begin
		logic [7:0] d;
		void'($urandom(32'h949C));
		repeat (10) @(negedge clk_i);
		reset_i = 1'h0;
		repeat (4) @(negedge clk_i);
		for (int c = 0; c < 4; c++) begin
			cfg[c] = 7'(c);
			rd(8'h0B + 8'(c), 8'(c));
		end
		rd(8'h0F, 8'h00);
		ch_sample_i = 16'($urandom);
		run(1'h0);
		// Pass 1 uses edge slots 63, 31, 32 and a slot clash in half-frame format.
		for (int it = 0; it < 4; it++) begin
			for (int c = 0; c < 4; c++) begin
				d = it == 1 ? 8'(32'h1F201FFF >> (8 * c)) : 8'($urandom);
				wr(8'h0B + 8'(c), d);
				cfg[c] = d[6:0];
				rd(8'h0B + 8'(c), {1'h0, d[6:0]});
			end
			wr(8'h0A, 8'hFF);
			ch_sample_i = 16'($urandom);
			fill_hiz_i = it[1];
			run(it[0]);
		end
		tally_and_finish();
	end
endmodule // tb_top
bind ascm_slot_map ascm_monitor u_mon (.clk_i(clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
	.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rdata_o(reg_rdata_o), .bclk_i(bclk_i),
	.prim_data_o(prim_data_o), .prim_oe_o(prim_oe_o), .sec_data_o(sec_data_o), .sec_oe_o(sec_oe_o));
`default_nettype wire
